// *** inc/pli_consts.vh ***
/*
 Timing counts, register offsets, field positions and reset values for the lamp block.
 Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef PLI_CONSTS_VH
`define PLI_CONSTS_VH

`define PLI_CLK_MHZ 100
`define PLI_RX_MS 20
`define PLI_COL_US 120
`define PLI_ACT_MS 4
`define PLI_FAST_MS 50
`define PLI_RX_CYC (`PLI_RX_MS * 1000 * `PLI_CLK_MHZ)
`define PLI_COL_CYC (`PLI_COL_US * `PLI_CLK_MHZ)
`define PLI_ACT_CYC (`PLI_ACT_MS * 1000 * `PLI_CLK_MHZ)
`define PLI_FAST_CYC (`PLI_FAST_MS * 1000 * `PLI_CLK_MHZ)

`define PLI_REG_CTRL 8'h00
`define PLI_REG_STAT 8'h04
`define PLI_REG_IRQ_STAT 8'h08
`define PLI_REG_IRQ_MASK 8'h0c

`define PLI_CTRL_FLASH_BIT 0
`define PLI_CTRL_RST 32'h00000000
`define PLI_MASK_RST 4'h0

`define PLI_EV_COL10 0
`define PLI_EV_COL100 1
`define PLI_EV_FAULT 2
`define PLI_EV_ACT 3

`define PLI_RESP_OKAY 2'b00
`define PLI_RESP_SLVERR 2'b10

`endif

// *** src/pli_stretch.v ***
/*
 One-shot lamp stretcher: on for ON_CYC cycles, then dark for as long.
 Assumes trig is a level or pulse synchronous to mclk.
*/
module pli_stretch #(
  parameter ON_CYC = 12000
) (
  input wire mclk,
  input wire reset_n,
  input wire trig,
  output reg lamp,
  output reg busy
);
  reg [31:0] cnt;
  reg dark;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 32'h00000000;
      lamp <= 1'b0;
      dark <= 1'b0;
      busy <= 1'b0;
    end else if (!busy) begin
      // Triggers while lit or dark are dropped, never extend
      if (trig) begin
        lamp <= 1'b1;
        busy <= 1'b1;
        cnt <= 32'h00000000;
      end
    end else if (cnt == ON_CYC - 1) begin
      cnt <= 32'h00000000;
      if (dark) begin
        dark <= 1'b0;
        // Relight on the edge the off-period ends, so a held trigger sees equal halves
        if (trig) begin
          lamp <= 1'b1;
        end else begin
          busy <= 1'b0;
        end
      end else begin
        lamp <= 1'b0;
        dark <= 1'b1;
      end
    end else begin
      cnt <= cnt + 32'h00000001;
    end
  end
endmodule // pli_stretch

// *** src/pli_led_top.v ***
/*
 Lamp logic for the fourth indicator mode: per-port link and receive lamps,
 speed lamps, per-segment collision and activity lamps, global fault and
 backup supply lamps, plus an AXI4-Lite slave for control, status and interrupts.
 Assumes all status inputs are synchronous to mclk.
*/
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`include "pli_consts.vh"

// Notes on behaviour
// - A port lamp is lit steadily while its link is good and the port is not cut off.
// - Receive traffic on a port blinks its lamp with a 20 ms pulse.
// - Every stretched on-period is followed by an equal off-period before relighting.
// - Collision and activity lamps exist per segment, 10 and 100 Mbps, not per port.
// - A collision on a segment lights its collision lamp for about 120 us.
// - Collisions while the collision lamp is lit are ignored.
// - Activity on a segment lights its activity lamp for about 4 ms.
// - Activity while the activity lamp is lit is ignored.
// - The fault lamp shows any port cut off, or backup supply present and faulty.
module pli_led_top #(
  parameter NPORT = 8,
  parameter RX_CYC = `PLI_RX_CYC,
  parameter ACT_CYC = `PLI_ACT_CYC,
  parameter FAST_CYC = `PLI_FAST_CYC
) (
  input wire mclk,
  input wire reset_n,
  input wire [NPORT-1:0] link_ok,
  input wire [NPORT-1:0] port_cut_off,
  input wire [NPORT-1:0] port_is_100m,
  input wire [NPORT-1:0] rx_activity,
  input wire col_10m,
  input wire col_100m,
  input wire act_10m,
  input wire act_100m,
  input wire backup_supply_present,
  input wire backup_supply_fault,
  output reg [NPORT-1:0] port_link_lamp,
  output reg [NPORT-1:0] port_speed_lamp,
  output reg col_10m_lamp,
  output reg col_100m_lamp,
  output reg act_10m_lamp,
  output reg act_100m_lamp,
  output reg global_fault_lamp,
  output reg backup_fault_lamp,
  output reg irq,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  reg auto_flash_mode;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  reg [31:0] fast_cnt;
  reg fast_phase;
  reg fault_q;
  wire [NPORT-1:0] rx_lamp;
  wire [NPORT-1:0] rx_busy;
  wire c10_l;
  wire c100_l;
  wire a10_l;
  wire a100_l;
  wire c10_b;
  wire c100_b;
  wire a10_b;
  wire a100_b;
  wire fault_now;
  wire [3:0] events;

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_rx
      pli_stretch #(.ON_CYC(RX_CYC)) u_rx (
        .mclk(mclk),
        .reset_n(reset_n),
        .trig(rx_activity[g] & link_ok[g] & ~port_cut_off[g]),
        .lamp(rx_lamp[g]),
        .busy(rx_busy[g])
      );
    end
  endgenerate

  // One collision and one activity stretcher per segment, shared by all ports on it
  pli_stretch #(.ON_CYC(`PLI_COL_CYC)) u_c10 (
    .mclk(mclk),
    .reset_n(reset_n),
    .trig(col_10m),
    .lamp(c10_l),
    .busy(c10_b)
  );
  pli_stretch #(.ON_CYC(`PLI_COL_CYC)) u_c100 (
    .mclk(mclk),
    .reset_n(reset_n),
    .trig(col_100m),
    .lamp(c100_l),
    .busy(c100_b)
  );
  pli_stretch #(.ON_CYC(ACT_CYC)) u_a10 (
    .mclk(mclk),
    .reset_n(reset_n),
    .trig(act_10m),
    .lamp(a10_l),
    .busy(a10_b)
  );
  pli_stretch #(.ON_CYC(ACT_CYC)) u_a100 (
    .mclk(mclk),
    .reset_n(reset_n),
    .trig(act_100m),
    .lamp(a100_l),
    .busy(a100_b)
  );

  assign fault_now = (|port_cut_off) | (backup_supply_present & backup_supply_fault);

  // Interrupt events: collision lamp lighting, fault rising, any activity lamp lighting
  assign events = {(a10_l & ~act_10m_lamp) | (a100_l & ~act_100m_lamp),
                   fault_now & ~fault_q,
                   c100_l & ~col_100m_lamp,
                   c10_l & ~col_10m_lamp};

  // Fast blink divider, free running
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fast_cnt <= 32'h00000000;
      fast_phase <= 1'b0;
    end else if (fast_cnt == FAST_CYC - 1) begin
      fast_cnt <= 32'h00000000;
      fast_phase <= ~fast_phase;
    end else begin
      fast_cnt <= fast_cnt + 32'h00000001;
    end
  end

  integer i;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      port_link_lamp <= {NPORT{1'b0}};
      port_speed_lamp <= {NPORT{1'b0}};
      col_10m_lamp <= 1'b0;
      col_100m_lamp <= 1'b0;
      act_10m_lamp <= 1'b0;
      act_100m_lamp <= 1'b0;
      global_fault_lamp <= 1'b0;
      backup_fault_lamp <= 1'b0;
      fault_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      for (i = 0; i < NPORT; i = i + 1) begin
        // Receive blink shows as a dark gap in the steady lamp
        if (link_ok[i] && !port_cut_off[i]) begin
          port_link_lamp[i] <= ~rx_lamp[i];
        end else begin
          port_link_lamp[i] <= 1'b0;
        end
        if (auto_flash_mode) begin
          if (!link_ok[i]) begin
            port_speed_lamp[i] <= fast_phase;
          end else begin
            port_speed_lamp[i] <= port_is_100m[i];
          end
        end else begin
          port_speed_lamp[i] <= port_is_100m[i];
        end
      end
      col_10m_lamp <= c10_l;
      col_100m_lamp <= c100_l;
      act_10m_lamp <= a10_l;
      act_100m_lamp <= a100_l;
      global_fault_lamp <= fault_now;
      backup_fault_lamp <= backup_supply_present & backup_supply_fault;
      fault_q <= fault_now;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // AXI4-Lite write: address and data taken in either order
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PLI_RESP_OKAY;
      auto_flash_mode <= 1'b0;
      irq_mask <= `PLI_MASK_RST;
      irq_stat <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Hardware set wins over a write-one clear in the same cycle
      if (do_write && aw_addr == `PLI_REG_IRQ_STAT && w_strb[0]) begin
        irq_stat <= (irq_stat & ~w_data[3:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PLI_RESP_OKAY;
        case (aw_addr)
          `PLI_REG_CTRL: begin
            if (w_strb[0]) begin
              auto_flash_mode <= w_data[`PLI_CTRL_FLASH_BIT];
            end
          end
          `PLI_REG_IRQ_MASK: begin
            if (w_strb[0]) begin
              irq_mask <= w_data[3:0];
            end
          end
          `PLI_REG_STAT: begin
          end
          `PLI_REG_IRQ_STAT: begin
          end
          default: begin
            s_axi_bresp <= `PLI_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // AXI4-Lite read
  reg [31:0] rd_word;
  reg rd_bad;
  always @* begin
    rd_word = 32'h00000000;
    rd_bad = 1'b0;
    case (s_axi_araddr)
      `PLI_REG_CTRL: rd_word = {31'h00000000, auto_flash_mode};
      `PLI_REG_STAT: rd_word = {24'h000000, backup_fault_lamp, global_fault_lamp,
                                act_100m_lamp, act_10m_lamp, col_100m_lamp,
                                col_10m_lamp, 1'b0, irq};
      `PLI_REG_IRQ_STAT: rd_word = {28'h0000000, irq_stat};
      `PLI_REG_IRQ_MASK: rd_word = {28'h0000000, irq_mask};
      default: rd_bad = 1'b1;
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PLI_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_bad ? `PLI_RESP_SLVERR : `PLI_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // pli_led_top

// *** verif/pli_led_props.sv ***
/* Port checker for the lamp block.
 Assumes it is bound to the top module and sees only its ports. */
`include "pli_consts.vh"
module pli_led_props #(
  parameter NPORT = 8,
  parameter ACT_CYC = 16
) (
  input wire mclk,
  input wire reset_n,
  input wire [NPORT-1:0] link_ok,
  input wire [NPORT-1:0] port_cut_off,
  input wire [NPORT-1:0] port_is_100m,
  input wire col_100m,
  input wire act_10m,
  input wire backup_supply_present,
  input wire backup_supply_fault,
  input wire [NPORT-1:0] port_link_lamp,
  input wire [NPORT-1:0] port_speed_lamp,
  input wire col_10m_lamp,
  input wire col_100m_lamp,
  input wire act_10m_lamp,
  input wire global_fault_lamp
);
  timeunit 1ns;
  timeprecision 100ps;
  logic a_prev, c_prev;
  logic [31:0] a_run, c_run;
  wire a_fall = a_prev && !act_10m_lamp;
  wire a_rise = !a_prev && act_10m_lamp;
  wire c_fall = c_prev && !col_10m_lamp;
  wire c_rise = !c_prev && col_10m_lamp;
  // Runs start huge so the dark time after reset never counts as a short off-period
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      a_prev <= 1'b0;
      c_prev <= 1'b0;
      a_run <= 32'h80000000;
      c_run <= 32'h80000000;
    end else begin
      a_prev <= act_10m_lamp;
      c_prev <= col_10m_lamp;
      a_run <= (act_10m_lamp != a_prev) ? 32'h1 : a_run + 32'h1;
      c_run <= (col_10m_lamp != c_prev) ? 32'h1 : c_run + 32'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence act_lit; !act_10m_lamp ##1 act_10m_lamp; endsequence
  sequence col_lit; !col_100m_lamp ##1 col_100m_lamp; endsequence
  AST_ACT_CAUSE:
    assert property (act_lit |-> $past(act_10m, 2)) else $error("activity lamp lit unprompted");
  AST_COL_CAUSE:
    assert property (col_lit |-> $past(col_100m, 2)) else $error("collision lamp lit unprompted");
  AST_ACT_ON:
    assert property (a_fall |-> a_run == ACT_CYC) else $error("activity on-time wrong");
  AST_ACT_OFF:
    assert property (a_rise |-> a_run >= ACT_CYC) else $error("activity off-time short");
  AST_COL_ON:
    assert property (c_fall |-> c_run == `PLI_COL_CYC) else $error("collision on-time wrong");
  AST_COL_OFF:
    assert property (c_rise |-> c_run >= `PLI_COL_CYC) else $error("collision off-time short");
  AST_LINK:
    assert property ($past(reset_n) |-> (port_link_lamp & ~$past(link_ok & ~port_cut_off)) == '0)
    else $error("link lamp lit without good link");
  AST_FAULT:
    assert property ($past(reset_n) |-> global_fault_lamp ==
      $past(|port_cut_off || (backup_supply_present && backup_supply_fault)))
    else $error("fault lamp wrong");
  AST_SPEED:
    assert property ($past(reset_n) |-> (port_speed_lamp & $past(link_ok)) ==
      $past(link_ok & port_is_100m)) else $error("speed lamp wrong with link up");
endmodule // pli_led_props

bind pli_led_top pli_led_props #(.NPORT(NPORT), .ACT_CYC(ACT_CYC)) pli_led_props_inst (
  .mclk(mclk), .reset_n(reset_n), .link_ok(link_ok), .port_cut_off(port_cut_off),
  .port_is_100m(port_is_100m), .col_100m(col_100m), .act_10m(act_10m),
  .backup_supply_present(backup_supply_present), .backup_supply_fault(backup_supply_fault),
  .port_link_lamp(port_link_lamp), .port_speed_lamp(port_speed_lamp),
  .col_10m_lamp(col_10m_lamp), .col_100m_lamp(col_100m_lamp),
  .act_10m_lamp(act_10m_lamp), .global_fault_lamp(global_fault_lamp)
);

// *** verif/pli_lamp_model.sv ***
/* Lamp model: measures how long a lamp was last lit and last dark.
 Assumes the lamp is a high-active level synchronous to mclk. */
module pli_lamp_model (
  input wire mclk,
  input wire reset_n,
  input wire lamp,
  output logic [31:0] on_len,
  output logic [31:0] off_len
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev;
  logic [31:0] run;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b0;
      run <= 32'h0;
      on_len <= 32'h0;
      off_len <= 32'h0;
    end else begin
      prev <= lamp;
      run <= (lamp != prev) ? 32'h1 : run + 32'h1;
      if (lamp != prev && prev) on_len <= run;
      if (lamp != prev && !prev) off_len <= run;
    end
  end
endmodule // pli_lamp_model

// *** verif/tb.sv ***
/* Self-checking bench for the lamp block.
 Assumes shortened receive and activity stretch parameters, full 120 us collision stretch, and lamp models on three lamps. */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RX = 20;
  localparam int AC = 16;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] link_ok, port_cut_off, port_is_100m, rx_activity, s_axi_awaddr, s_axi_araddr;
  logic col_10m, col_100m, act_10m, act_100m, backup_supply_present, backup_supply_fault;
  logic [7:0] port_link_lamp, port_speed_lamp;
  logic col_10m_lamp, col_100m_lamp, act_10m_lamp, act_100m_lamp;
  logic global_fault_lamp, backup_fault_lamp, irq;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, rx_off, a_on, a_off, c_on, c_off;
  logic [3:0] s_axi_wstrb;
  int errors = 0;
  int checks = 0;
  int seed = 62;
  always #5 mclk = ~mclk;
  pli_led_top #(.RX_CYC(RX), .ACT_CYC(AC), .FAST_CYC(8)) pli_led_top_inst (.*);
  pli_lamp_model rx_m (.mclk(mclk), .reset_n(reset_n), .lamp(port_link_lamp[0]),
    .on_len(), .off_len(rx_off));
  pli_lamp_model act_m (.mclk(mclk), .reset_n(reset_n), .lamp(act_10m_lamp),
    .on_len(a_on), .off_len(a_off));
  pli_lamp_model col_m (.mclk(mclk), .reset_n(reset_n), .lamp(col_10m_lamp),
    .on_len(c_on), .off_len(c_off));
  function logic f_fault(input logic [7:0] c, input logic p, input logic f);
    return |c || (p && f);
  endfunction
  task test_done;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bail(input int n);
    if (n >= 200) begin
      errors++;
      test_done();
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Both tasks start and end right after a rising edge and sample the answer one edge before they end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    // One idle edge so a following call never re-drives the ready in this time step
    @(posedge mclk);
    bail(n);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge mclk);
    bail(n);
  endtask
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] o, n8;
    {link_ok, port_cut_off, port_is_100m, rx_activity, s_axi_awaddr, s_axi_araddr} = '0;
    {col_10m, col_100m, act_10m, act_100m, backup_supply_present, backup_supply_fault} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    cyc(8);
    reset_n <= 1'b1;
    cyc(1);
    axi_rd(8'h00, d, r);
    chk(d, 32'h0);
    axi_rd(8'h0c, d, r);
    chk(d, 32'h0);
    axi_rd(8'h10, d, r);
    chk(r, 2'b10);
    axi_wr(8'h10, 32'h1, r);
    chk(r, 2'b10);
    axi_wr(8'h04, 32'hff, r);
    chk(r, 2'b00);
    repeat (40) begin
      link_ok <= $random(seed);
      port_cut_off <= $random(seed) & $random(seed);
      port_is_100m <= $random(seed);
      {backup_supply_present, backup_supply_fault} <= $random(seed);
      cyc(3);
      chk(port_link_lamp, link_ok & ~port_cut_off);
      chk(global_fault_lamp, f_fault(port_cut_off, backup_supply_present, backup_supply_fault));
      chk(port_speed_lamp, port_is_100m);
      chk(backup_fault_lamp, backup_supply_present & backup_supply_fault);
    end
    axi_wr(8'h00, 32'h1, r);
    {link_ok, port_is_100m, port_cut_off} <= 24'h0f0500;
    {backup_supply_present, backup_supply_fault} <= 2'b00;
    cyc(4);
    o = 8'h00;
    n8 = 8'hff;
    repeat (20) begin
      cyc(1);
      o = o | port_speed_lamp;
      n8 = n8 & port_speed_lamp;
    end
    chk({o, n8}, 16'hf505);
    rx_activity <= 8'h01;
    cyc(1);
    rx_activity <= 8'h00;
    cyc(3 * RX);
    chk(rx_off, RX);
    act_10m <= 1'b1;
    cyc(60);
    act_10m <= 1'b0;
    cyc(50);
    chk({a_on, a_off}, {AC, AC});
    {act_100m, col_100m} <= 2'b11;
    cyc(3);
    {act_100m, col_100m} <= 2'b00;
    chk({act_10m_lamp, act_100m_lamp, col_10m_lamp, col_100m_lamp}, 4'b0101);
    col_10m <= 1'b1;
    cyc(24050);
    col_10m <= 1'b0;
    cyc(12100);
    chk(c_on, 32'd12000);
    chk(c_off - 32'd12000 <= 32'd2, 1);
    axi_rd(8'h08, d, r);
    chk({irq, d[0]}, 2'b01);
    axi_wr(8'h0c, 32'h1, r);
    cyc(3);
    chk(irq, 1);
    axi_wr(8'h08, 32'hf, r);
    cyc(3);
    chk(irq, 0);
    axi_rd(8'h08, d, r);
    chk(d, 32'h0);
    test_done();
  end
endmodule // tb
